/* File: design/rsc_top.sv */
// Reset source control: reset pin select, reset cause flags, low-voltage reset control.
// Assumes sleep_mode, wdt inputs and the register port come from sys_clk logic;
// low_supply and ext_reset_n_pin come from outside and are synchronised here.
//
// What this block does
// RL1: Select code 0x55 gives pin to I/O; 0xAA makes it reset input.
// RL2: Any other select code resets the device after the soft reset delay.
// RL3: A reset from an illegal select code sets flag bit 3.
// RL4: Flag bit 3 is cleared only by a software write.
// RL5: All resets restore select register to 0x55, except sleep watchdog warm reset.
// RL6: Reset pin selection overrides every other function of the shared pin.
// RL7: Flag register bits 7 to 4 always read zero.
// RL8: Low-voltage monitoring runs when enabled, but never in sleep or idle; the code gates on sleep_mode only and has no idle input.
// RL9: Low supply must last beyond the filter time before it resets.
// RL10: A genuine low-voltage reset sets flag bit 2.
// RL11: Threshold codes 66,55,33,99,AA pick levels; F0 disables monitoring.
// RL12: Undefined threshold code resets after delay and restores power-on value.
// RL13: A genuine low-voltage reset keeps the threshold control contents.
// RL14: Undefined threshold code sets flag bit 1, cleared only by software.
// RL15: Flag bit 2 is set by hardware, cleared only by software.
// RL16: Writing 0x55 to programming control one resets the whole device.
// RL17: Watchdog timeout in normal mode resets and sets timeout flag.
// RL18: Watchdog timeout in sleep clears PC and SP, sets timeout and power-down.
// RL19: Power-on leaves threshold control at the 1.7 V code.
// RL20: Illegal watchdog enable code resets after delay and sets flag bit 0.
// RL21: Soft delay and filter time are parameterised cycle counters.
//
// Local design decisions: the register addresses and strobed register access.

`timescale 1ns/1ns
`default_nettype none

module rsc_top
	import rsc_pkg::*;
#(
	parameter int SOFT_RESET_CYC = RSC_SOFT_RESET_CYC,
	parameter int LV_FILTER_CYC = RSC_LV_FILTER_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire rsc_bus_req_t bus_req,
	output logic [7:0] rd_data,
	input wire logic low_supply,
	input wire logic ext_reset_n_pin,
	input wire logic sleep_mode,
	input wire logic watchdog_timeout,
	input wire logic [4:0] watchdog_enable_code,
	output logic pin_reset_select,
	output logic lv_monitor_enable,
	output rsc_threshold_t lv_threshold,
	output rsc_reset_out_t reset_out
);

	// ==========================================================
	// Registers and decode
	logic [7:0] func_sel;
	logic [7:0] lv_ctrl;
	logic [RSC_FLAG_W-1:0] flags;
	logic [RSC_CNT_W-1:0] soft_cnt;
	logic [RSC_CNT_W-1:0] lv_cnt;
	logic [2:0] lv_sync;
	logic [2:0] pin_sync;
	logic lv_low;
	logic pin_low;
	logic sel_illegal;
	logic lv_illegal;
	logic wdt_illegal;
	logic any_illegal;
	logic lv_defined;
	logic soft_fire;
	logic fire_lv;
	logic fire_pin;
	logic fire_iap;
	logic fire_wdt_norm;
	logic fire_wdt_sleep;
	logic full_reset;
	logic wr_flags;
	rsc_threshold_t next_threshold;

	localparam logic [RSC_CNT_W-1:0] SOFT_LAST = RSC_CNT_W'(SOFT_RESET_CYC - 1);
	localparam logic [RSC_CNT_W-1:0] LV_LAST = RSC_CNT_W'(LV_FILTER_CYC - 1);
	localparam logic [RSC_CNT_W-1:0] CNT_ONE = RSC_CNT_W'(1);

	always_comb begin
		lv_defined = 1'b1;
		next_threshold = RSC_TH_1V7;
		unique case (lv_ctrl) // RL11
			RSC_LV_1V7: next_threshold = RSC_TH_1V7;
			RSC_LV_1V9: next_threshold = RSC_TH_1V9;
			RSC_LV_2V55: next_threshold = RSC_TH_2V55;
			RSC_LV_3V15: next_threshold = RSC_TH_3V15;
			RSC_LV_3V8: next_threshold = RSC_TH_3V8;
			default: lv_defined = 1'b0;
		endcase
	end

	assign sel_illegal = (func_sel != RSC_SEL_IO) && (func_sel != RSC_SEL_PIN); // RL2
	assign lv_illegal = !lv_defined && (lv_ctrl != RSC_LV_OFF); // RL12
	assign wdt_illegal = (watchdog_enable_code != RSC_WDT_ENABLE)
		&& (watchdog_enable_code != RSC_WDT_DISABLE); // RL20
	assign any_illegal = sel_illegal || lv_illegal || wdt_illegal;
	assign soft_fire = any_illegal && (soft_cnt >= SOFT_LAST); // RL21
	assign fire_lv = lv_monitor_enable && lv_low && (lv_cnt >= LV_LAST); // RL9
	assign fire_pin = pin_reset_select && pin_low; // RL6
	assign fire_iap = bus_req.wr && (bus_req.addr == RSC_ADDR_PROG_CTRL_ONE)
		&& (bus_req.wdata == RSC_PROG_RESET_KEY); // RL16
	assign fire_wdt_norm = watchdog_timeout && !sleep_mode; // RL17
	assign fire_wdt_sleep = watchdog_timeout && sleep_mode; // RL18
	assign full_reset = soft_fire || fire_lv || fire_pin || fire_iap || fire_wdt_norm;
	assign wr_flags = bus_req.wr && (bus_req.addr == RSC_ADDR_FLAGS);

	// ==========================================================
	// Input synchronisers
	// A change counts only once the second and third stages agree, which
	// also rejects a single-cycle glitch on the external pins.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lv_sync <= 3'b000;
			pin_sync <= 3'b111;
			lv_low <= 1'b0;
			pin_low <= 1'b0;
		end else begin
			lv_sync <= {lv_sync[1:0], low_supply};
			pin_sync <= {pin_sync[1:0], ext_reset_n_pin};
			if (lv_sync[1] == lv_sync[2]) begin
				lv_low <= lv_sync[2];
			end
			if (pin_sync[1] == pin_sync[2]) begin
				pin_low <= !pin_sync[2];
			end
		end
	end

	// ==========================================================
	// Delay counters
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			soft_cnt <= '0;
		end else if (!any_illegal || full_reset) begin
			soft_cnt <= '0;
		end else begin
			soft_cnt <= soft_cnt + CNT_ONE; // RL21
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lv_cnt <= '0;
		end else if (!(lv_monitor_enable && lv_low) || full_reset) begin
			lv_cnt <= '0; // RL9
		end else begin
			lv_cnt <= lv_cnt + CNT_ONE; // RL21
		end
	end

	// ==========================================================
	// Reset function select register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			func_sel <= RSC_SEL_IO;
		end else if (full_reset) begin
			func_sel <= RSC_SEL_IO; // RL5
		end else if (bus_req.wr && bus_req.addr == RSC_ADDR_FUNC_SEL) begin
			func_sel <= bus_req.wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_reset_select <= 1'b0;
		end else begin
			pin_reset_select <= (func_sel == RSC_SEL_PIN); // RL1
		end
	end

	// ==========================================================
	// Low-voltage reset control register
	// A genuine low-voltage reset keeps the contents so the chosen level
	// survives the brown-out; every other full reset restores power-on.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lv_ctrl <= RSC_LV_POR; // RL19
		end else if (full_reset && !(fire_lv && !soft_fire && !fire_pin && !fire_iap
			&& !fire_wdt_norm)) begin
			lv_ctrl <= RSC_LV_POR; // RL12
		end else if (fire_lv) begin
			lv_ctrl <= lv_ctrl; // RL13
		end else if (bus_req.wr && bus_req.addr == RSC_ADDR_LV_CTRL) begin
			lv_ctrl <= bus_req.wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lv_monitor_enable <= 1'b0;
			lv_threshold <= RSC_TH_1V7;
		end else begin
			lv_monitor_enable <= lv_defined && !sleep_mode && !full_reset; // RL8
			lv_threshold <= next_threshold;
		end
	end

	// ==========================================================
	// Reset cause flags
	// Hardware sets win over a software write in the same cycle, so no
	// cause is lost to a clear that races it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags <= RSC_FLAGS_POR[RSC_FLAG_W-1:0];
		end else begin
			if (wr_flags) begin
				flags <= bus_req.wdata[RSC_FLAG_W-1:0]; // RL4
			end
			if (soft_fire && sel_illegal) begin
				flags[RSC_FLAG_SEL_FAULT] <= 1'b1; // RL3
			end
			if (fire_lv) begin
				flags[RSC_FLAG_LV_EVENT] <= 1'b1; // RL10
			end
			if (soft_fire && lv_illegal) begin
				flags[RSC_FLAG_LV_SEL_FAULT] <= 1'b1; // RL14
			end
			if (soft_fire && wdt_illegal) begin
				flags[RSC_FLAG_WDT_FAULT] <= 1'b1; // RL20
			end
		end
	end

	// ==========================================================
	// Reset outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reset_out <= '0;
		end else begin
			reset_out.device_reset <= full_reset; // RL2
			reset_out.warm_reset <= fire_wdt_sleep && !full_reset; // RL18
			reset_out.set_timeout_flag <= watchdog_timeout; // RL17
			reset_out.set_power_down_flag <= fire_wdt_sleep && !full_reset; // RL18
		end
	end

	// ==========================================================
	// Register read port
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_data <= RSC_ZERO8;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				RSC_ADDR_FUNC_SEL: rd_data <= func_sel;
				RSC_ADDR_FLAGS: rd_data <= {{(8-RSC_FLAG_W){1'b0}}, flags}; // RL7
				RSC_ADDR_LV_CTRL: rd_data <= lv_ctrl;
				default: rd_data <= RSC_ZERO8;
			endcase
		end else begin
			rd_data <= RSC_ZERO8;
		end
	end

	// ==========================================================
	// Assertions
	property p_pin_route;
		@(posedge sys_clk) disable iff (rst)
		(func_sel == RSC_SEL_PIN) ##1 (func_sel == RSC_SEL_PIN) |-> pin_reset_select;
	endproperty
	a_pin_route: assert property (p_pin_route) else $error("pin select not routed"); // RL1

	property p_sel_delay;
		@(posedge sys_clk) disable iff (rst)
		sel_illegal && !full_reset && (soft_cnt == '0) |-> !reset_out.device_reset;
	endproperty
	a_sel_delay: assert property (p_sel_delay) else $error("select reset too early"); // RL2

	property p_sel_fire;
		@(posedge sys_clk) disable iff (rst)
		sel_illegal && soft_cnt == SOFT_LAST |=> reset_out.device_reset
			&& flags[RSC_FLAG_SEL_FAULT];
	endproperty
	a_sel_fire: assert property (p_sel_fire) else $error("select fault missing"); // RL3

	property p_sel_flag_hold;
		@(posedge sys_clk) disable iff (rst)
		flags[RSC_FLAG_SEL_FAULT] && !wr_flags |=> flags[RSC_FLAG_SEL_FAULT];
	endproperty
	a_sel_flag_hold: assert property (p_sel_flag_hold) else $error("flag 3 lost"); // RL4

	property p_sel_restore;
		@(posedge sys_clk) disable iff (rst)
		reset_out.device_reset |-> func_sel == RSC_SEL_IO;
	endproperty
	a_sel_restore: assert property (p_sel_restore) else $error("select not restored"); // RL5

	property p_pin_reset;
		@(posedge sys_clk) disable iff (rst)
		pin_reset_select && pin_low |=> reset_out.device_reset;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed"); // RL6

	property p_flag_upper;
		@(posedge sys_clk) disable iff (rst)
		$past(bus_req.rd) |-> rd_data[7:4] == 4'h0 || $past(bus_req.addr) != RSC_ADDR_FLAGS;
	endproperty
	a_flag_upper: assert property (p_flag_upper) else $error("upper flag bits set"); // RL7

	property p_sleep_off;
		@(posedge sys_clk) disable iff (rst)
		sleep_mode |=> !lv_monitor_enable;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("monitor on in sleep"); // RL8

	// A cycle without a qualified low supply must restart the filter, so the
	// next cycle can never fire; this needs a filter time of two cycles or more.
	property p_lv_filter;
		@(posedge sys_clk) disable iff (rst)
		!(lv_monitor_enable && lv_low) |=> !fire_lv;
	endproperty
	a_lv_filter: assert property (p_lv_filter) else $error("lv reset unfiltered"); // RL9

	property p_lv_event;
		@(posedge sys_clk) disable iff (rst)
		fire_lv |=> reset_out.device_reset && flags[RSC_FLAG_LV_EVENT];
	endproperty
	a_lv_event: assert property (p_lv_event) else $error("lv event flag missing"); // RL10

	property p_lv_flag_hold;
		@(posedge sys_clk) disable iff (rst)
		flags[RSC_FLAG_LV_EVENT] && !wr_flags |=> flags[RSC_FLAG_LV_EVENT];
	endproperty
	a_lv_flag_hold: assert property (p_lv_flag_hold) else $error("flag 2 lost"); // RL15

	property p_lv_restore;
		@(posedge sys_clk) disable iff (rst)
		soft_fire && lv_illegal |=> lv_ctrl == RSC_LV_POR && flags[RSC_FLAG_LV_SEL_FAULT];
	endproperty
	a_lv_restore: assert property (p_lv_restore) else $error("lv ctrl not restored"); // RL12

	property p_lv_keep;
		@(posedge sys_clk) disable iff (rst)
		fire_lv && !soft_fire && !fire_pin && !fire_iap && !fire_wdt_norm
			|=> lv_ctrl == $past(lv_ctrl);
	endproperty
	a_lv_keep: assert property (p_lv_keep) else $error("lv ctrl changed"); // RL13

	property p_iap;
		@(posedge sys_clk) disable iff (rst)
		fire_iap |=> reset_out.device_reset;
	endproperty
	a_iap: assert property (p_iap) else $error("program key reset missed"); // RL16

	property p_wdt_norm;
		@(posedge sys_clk) disable iff (rst)
		fire_wdt_norm |=> reset_out.device_reset && reset_out.set_timeout_flag
			&& !reset_out.set_power_down_flag;
	endproperty
	a_wdt_norm: assert property (p_wdt_norm) else $error("wdt normal reset wrong"); // RL17

	property p_wdt_sleep;
		@(posedge sys_clk) disable iff (rst)
		fire_wdt_sleep && !full_reset |=> reset_out.warm_reset && reset_out.set_timeout_flag
			&& reset_out.set_power_down_flag && !reset_out.device_reset;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("wdt sleep reset wrong"); // RL18

	property p_wdt_cfg;
		@(posedge sys_clk) disable iff (rst)
		soft_fire && wdt_illegal |=> flags[RSC_FLAG_WDT_FAULT];
	endproperty
	a_wdt_cfg: assert property (p_wdt_cfg) else $error("wdt cfg flag missing"); // RL20

	property p_soft_count;
		@(posedge sys_clk) disable iff (rst)
		soft_cnt != '0 |-> $past(any_illegal);
	endproperty
	a_soft_count: assert property (p_soft_count) else $error("soft delay counted idle"); // RL21

	c_sel_fire: cover property (@(posedge sys_clk) disable iff (rst) soft_fire && sel_illegal);
	c_lv_fire: cover property (@(posedge sys_clk) disable iff (rst) fire_lv);
	c_wdt_sleep: cover property (@(posedge sys_clk) disable iff (rst) fire_wdt_sleep);
	c_iap: cover property (@(posedge sys_clk) disable iff (rst) fire_iap);

endmodule : rsc_top

`default_nettype wire

/* File: design/rsc_pkg.sv */
// Shared constants and types for the reset source control block.
// Assumes a single 20 MHz system clock and an 8-bit register port.

package rsc_pkg;

	// ==========================================================
	// Clock and timing
	localparam int RSC_CLK_PERIOD_NS = 50;
	localparam int RSC_SOFT_RESET_DELAY_NS = 1000;
	localparam int RSC_LOW_VOLTAGE_FILTER_NS = 1000;
	// Least times, so both round up to whole cycles.
	localparam int RSC_SOFT_RESET_CYC =
		(RSC_SOFT_RESET_DELAY_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
	localparam int RSC_LV_FILTER_CYC =
		(RSC_LOW_VOLTAGE_FILTER_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
	localparam int RSC_CNT_W = 16;

	// ==========================================================
	// Register map
	localparam int RSC_ADDR_W = 3;
	localparam logic [2:0] RSC_ADDR_FUNC_SEL = 3'h0;
	localparam logic [2:0] RSC_ADDR_FLAGS = 3'h1;
	localparam logic [2:0] RSC_ADDR_LV_CTRL = 3'h2;
	localparam logic [2:0] RSC_ADDR_PROG_CTRL_ONE = 3'h3;

	// ==========================================================
	// Codes and reset values
	localparam logic [7:0] RSC_SEL_IO = 8'h55;
	localparam logic [7:0] RSC_SEL_PIN = 8'hAA;
	localparam logic [7:0] RSC_LV_1V7 = 8'h66;
	localparam logic [7:0] RSC_LV_1V9 = 8'h55;
	localparam logic [7:0] RSC_LV_2V55 = 8'h33;
	localparam logic [7:0] RSC_LV_3V15 = 8'h99;
	localparam logic [7:0] RSC_LV_3V8 = 8'hAA;
	localparam logic [7:0] RSC_LV_OFF = 8'hF0;
	localparam logic [7:0] RSC_LV_POR = RSC_LV_1V7;
	localparam logic [7:0] RSC_PROG_RESET_KEY = 8'h55;
	localparam logic [4:0] RSC_WDT_ENABLE = 5'h0A;
	localparam logic [4:0] RSC_WDT_DISABLE = 5'h15;
	localparam logic [7:0] RSC_FLAGS_POR = 8'h00;
	localparam logic [7:0] RSC_ZERO8 = 8'h00;

	// Flag bit positions.
	localparam int RSC_FLAG_SEL_FAULT = 3;
	localparam int RSC_FLAG_LV_EVENT = 2;
	localparam int RSC_FLAG_LV_SEL_FAULT = 1;
	localparam int RSC_FLAG_WDT_FAULT = 0;
	localparam int RSC_FLAG_W = 4;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		RSC_TH_1V7,
		RSC_TH_1V9,
		RSC_TH_2V55,
		RSC_TH_3V15,
		RSC_TH_3V8
	} rsc_threshold_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [RSC_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} rsc_bus_req_t;

	typedef struct packed {
		logic device_reset;
		logic warm_reset;
		logic set_timeout_flag;
		logic set_power_down_flag;
	} rsc_reset_out_t;

endpackage : rsc_pkg

/* File: test/tb_top.sv */
// Self-checking bench for the reset source control block.
// Assumes rsc_pkg and rsc_top are compiled first; the bench drives every port itself.
`timescale 1ns/1ns
`default_nettype none

module tb_top
	import rsc_pkg::*;
;
	// ==========================================================
	// Short counts keep the run brief; the soft delay and filter windows derive from them.
	localparam int SC = 4;
	localparam int LC = 4;

	logic sys_clk;
	logic rst;
	logic low_supply;
	logic ext_reset_n_pin;
	logic sleep_mode;
	logic watchdog_timeout;
	logic [4:0] watchdog_enable_code;
	rsc_bus_req_t bus_req;
	logic [7:0] rd_data;
	logic pin_reset_select;
	logic lv_monitor_enable;
	rsc_threshold_t lv_threshold;
	rsc_reset_out_t reset_out;
	int err_count;
	int checked;

	rsc_top #(.SOFT_RESET_CYC(SC), .LV_FILTER_CYC(LC)) uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.low_supply(low_supply),
		.ext_reset_n_pin(ext_reset_n_pin),
		.sleep_mode(sleep_mode),
		.watchdog_timeout(watchdog_timeout),
		.watchdog_enable_code(watchdog_enable_code),
		.pin_reset_select(pin_reset_select),
		.lv_monitor_enable(lv_monitor_enable),
		.lv_threshold(lv_threshold),
		.reset_out(reset_out)
	);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Helpers
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// Waits a bounded time for a full reset pulse and judges its moment.
	task automatic fire(input int lo, input int hi, input string m);
		int i;
		for (i = 0; i <= hi; i++) begin
			if (i > 0) @(posedge sys_clk);
			#1;
			if (reset_out.device_reset === 1'b1) break;
		end
		checked++;
		if (i > hi) begin
			err_count++;
			$display("MISMATCH t=%0t %s never fired", $time, m);
			summarize;
		end else if (i < lo) begin
			err_count++;
			$display("MISMATCH t=%0t %s fired early at %0d", $time, m, i);
		end
	endtask : fire

	task automatic quiet(input int n, input string m);
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			chk({4'h0, reset_out}, 8'h00, m);
		end
	endtask : quiet

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		bus_req <= '0;
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string m);
		@(posedge sys_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		bus_req <= '0;
		#1;
		chk(rd_data, e, m);
	endtask : rd

	// Pulses the watchdog timeout and gathers the reset outputs it causes.
	task automatic wdt(input logic s, input logic [3:0] e, input string m);
		logic [3:0] acc;
		acc = 4'h0;
		@(posedge sys_clk);
		sleep_mode <= s;
		@(posedge sys_clk);
		watchdog_timeout <= 1'b1;
		@(posedge sys_clk);
		watchdog_timeout <= 1'b0;
		repeat (4) begin
			#1;
			acc = acc | reset_out;
			@(posedge sys_clk);
		end
		sleep_mode <= 1'b0;
		chk({4'h0, acc}, {4'h0, e}, m);
	endtask : wdt

	// ==========================================================
	// Scenarios
	task automatic t_por;
		@(posedge sys_clk);
		#1;
		chk({7'h0, pin_reset_select}, 8'h00, "pin sel");
		chk({7'h0, lv_monitor_enable}, 8'h01, "lv en");
		chk({5'h0, lv_threshold}, 8'h00, "lv thr");
		rd(3'h0, 8'h55, "sel por");
		rd(3'h1, 8'h00, "flags por");
		rd(3'h2, 8'h66, "lv por");
	endtask : t_por

	task automatic t_thresh;
		logic [7:0] c [6];
		c = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
		for (int k = 0; k < 6; k++) begin
			wr(3'h2, c[k]);
			repeat (2) @(posedge sys_clk);
			#1;
			chk({7'h0, lv_monitor_enable}, {7'h0, k < 5}, "lv en");
			if (k < 5) chk({5'h0, lv_threshold}, k[7:0], "lv thr");
			rd(3'h2, c[k], "lv rb");
		end
		wr(3'h2, 8'h55);
		@(posedge sys_clk);
		sleep_mode <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({7'h0, lv_monitor_enable}, 8'h00, "lv sleep");
		@(posedge sys_clk);
		sleep_mode <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({7'h0, lv_monitor_enable}, 8'h01, "lv wake");
	endtask : t_thresh

	task automatic t_bad_sel;
		wr(3'h0, 8'h12);
		fire(SC - 1, SC + 2, "bad sel");
		rd(3'h1, 8'h08, "sel flag");
		rd(3'h0, 8'h55, "sel restore");
		repeat (10) @(posedge sys_clk);
		rd(3'h1, 8'h08, "sel flag kept");
		wr(3'h1, 8'hF0);
		rd(3'h1, 8'h00, "flag clear");
	endtask : t_bad_sel

	task automatic t_bad_lv;
		wr(3'h2, 8'hA5);
		fire(SC - 1, SC + 2, "bad lv");
		rd(3'h2, 8'h66, "lv restore");
		rd(3'h1, 8'h02, "lv sel flag");
		wr(3'h1, 8'h00);
		rd(3'h1, 8'h00, "lv sel clear");
	endtask : t_bad_lv

	task automatic t_bad_wdt;
		@(posedge sys_clk);
		watchdog_enable_code <= 5'h15;
		quiet(SC + 4, "wdt off legal");
		@(posedge sys_clk);
		watchdog_enable_code <= 5'h03;
		fire(SC - 1, SC + 3, "bad wdt");
		@(posedge sys_clk);
		watchdog_enable_code <= 5'h0A;
		repeat (2) @(posedge sys_clk);
		rd(3'h1, 8'h01, "wdt flag");
		wr(3'h1, 8'h00);
	endtask : t_bad_wdt

	task automatic t_lv;
		wr(3'h2, 8'h33);
		@(posedge sys_clk);
		low_supply <= 1'b1;
		repeat (2) @(posedge sys_clk);
		low_supply <= 1'b0;
		quiet(LC + 10, "lv glitch");
		@(posedge sys_clk);
		low_supply <= 1'b1;
		fire(LC, LC + 8, "lv event");
		@(posedge sys_clk);
		low_supply <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rd(3'h2, 8'h33, "lv kept");
		rd(3'h1, 8'h04, "lv flag");
		repeat (5) @(posedge sys_clk);
		rd(3'h1, 8'h04, "lv flag kept");
		wr(3'h1, 8'h00);
		rd(3'h1, 8'h00, "lv flag clear");
	endtask : t_lv

	task automatic t_pin;
		// A low pin must be ignored while it serves as plain I/O.
		@(posedge sys_clk);
		ext_reset_n_pin <= 1'b0;
		quiet(8, "pin as io");
		@(posedge sys_clk);
		ext_reset_n_pin <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wr(3'h0, 8'hAA);
		repeat (2) @(posedge sys_clk);
		#1;
		chk({7'h0, pin_reset_select}, 8'h01, "pin sel");
		@(posedge sys_clk);
		ext_reset_n_pin <= 1'b0;
		fire(1, 6, "pin reset");
		@(posedge sys_clk);
		ext_reset_n_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		chk({7'h0, pin_reset_select}, 8'h00, "pin sel off");
		rd(3'h0, 8'h55, "pin restore");
		rd(3'h1, 8'h00, "pin flags");
	endtask : t_pin

	task automatic t_iap;
		wr(3'h3, 8'h77);
		quiet(4, "iap other");
		rd(3'h3, 8'h00, "iap read");
		wr(3'h5, 8'h12);
		quiet(SC + 3, "unmapped wr");
		rd(3'h5, 8'h00, "unmapped rd");
		wr(3'h0, 8'hAA);
		wr(3'h3, 8'h55);
		fire(0, 2, "iap key");
		rd(3'h0, 8'h55, "iap restore");
	endtask : t_iap

	task automatic t_wdt;
		wr(3'h0, 8'hAA);
		wdt(1'b1, 4'b0111, "wdt sleep");
		rd(3'h0, 8'hAA, "warm keeps sel");
		wdt(1'b0, 4'b1010, "wdt normal");
		rd(3'h0, 8'h55, "wdt restore");
	endtask : t_wdt

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		bus_req = '0;
		low_supply = 1'b0;
		ext_reset_n_pin = 1'b1;
		sleep_mode = 1'b0;
		watchdog_timeout = 1'b0;
		watchdog_enable_code = 5'h0A;
		err_count = 0;
		checked = 0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_por;
		t_thresh;
		t_bad_sel;
		t_bad_lv;
		t_bad_wdt;
		t_lv;
		t_pin;
		t_iap;
		t_wdt;
		summarize;
	end

endmodule : tb_top

`default_nettype wire
